// File: pll_div_counter.sv
// one pll divide counter with high/low counts, bypass and odd select.
// assumes each system clock is half a vco cycle, so the odd-select
// half-cycle shift is one step; new settings wait for the period end.
`timescale 1ns/1ps
`default_nettype none

module pll_div_counter (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       loadStb,
   input  wire logic [7:0] highCount,
   input  wire logic [7:0] lowCount,
   input  wire logic       bypass,
   input  wire logic       oddSel,
   output logic            divClk,
   output logic            pending
);
   import pll_scan_pkg::*;

   logic [7:0]        hi_r;
   logic [7:0]        lo_r;
   logic              byp_r;
   logic              odd_r;
   logic              pend_r;
   logic [STEP_W-1:0] cnt_r;
   logic [STEP_W-1:0] cntNxt;
   logic [STEP_W-1:0] periodSteps;
   logic [STEP_W-1:0] highSteps;
   logic              wrap;

   always_comb begin
      if (byp_r) begin
         periodSteps = STEP_BYPASS;
         highSteps   = STEP_ONE;
      end else begin
         periodSteps = {1'b0, hi_r, 1'b0} + {1'b0, lo_r, 1'b0};
         // half cycle moved to low time
         highSteps   = {1'b0, hi_r, 1'b0} - {{(STEP_W-1){1'b0}}, odd_r};
      end
   end

   // a shrinking period must not strand the count above the new end
   assign wrap   = (cnt_r + STEP_ONE >= periodSteps);
   assign cntNxt = wrap ? '0 : cnt_r + STEP_ONE;

   // settings taken at own period end
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         hi_r  <= '0;
         lo_r  <= '0;
         byp_r <= 1'b1;
         odd_r <= 1'b0;
      end else if (wrap && pend_r) begin
         hi_r  <= highCount;
         lo_r  <= lowCount;
         byp_r <= bypass;
         odd_r <= oddSel;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pend_r <= 1'b0;
      end else if (loadStb) begin
         pend_r <= 1'b1;
      end else if (wrap) begin
         pend_r <= 1'b0;
      end
   end

   // high then low, falling at period split
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cnt_r  <= '0;
         divClk <= 1'b0;
      end else begin
         cnt_r  <= cntNxt;
         divClk <= (cntNxt < highSteps);
      end
   end

   assign pending = pend_r;

endmodule

`default_nettype wire

// File: pll_reconfig_scan_chain.sv
// pll reconfiguration scan chain: serial capture, update sequencing,
// divide counters and bandwidth code decoding.
// assumes scan inputs are synchronous to ref_clk and that ref_clk is
// the vco half-step clock of the counters.
//
// Notes on behaviour
// - the image is one serial chain of exactly 144 bits.
// - bits enter on serial data input, shifted on scan clock.
// - apply strobe after last bit loads configuration from the chain.
// - each counter takes its new setting at its own period end.
// - post-scale counters hold 8-bit high and 8-bit low counts.
// - duty is high or low count over their sum.
// - skip bit set bypasses counter, divide by one, other bits ignored.
// - skip clear divides by high plus low, falling on rising edge.
// - odd select shifts half a cycle from high to low time.
// - 18 bits per counter, seven counters, nine pump, nine filter.
// - first bit shifted is low-count lsb of fifth post-scale counter.
// - last bit shifted is msb of the loop-filter group.
// - pump code accepts 000, 100, 110, 111 as 0, 1, 3, 7.
// - resistor code accepts 0,3,4,8,16,19,20,24,27,28,30 in binary.
// - capacitor code accepts 00, 01, 11 as 0, 1, 3.
// - bypass flag is bit 8 of each counter's 9-bit group.
// - done indicator rises on apply, falls when counters updated.
`timescale 1ns/1ps
`default_nettype none

module pll_reconfig_scan_chain (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       scanClk,
   input  wire logic       scanClkEn,
   input  wire logic       scanData,
   input  wire logic       configUpdate,
   output logic            scanReady,
   output logic            scanDone,
   output logic [4:0]      postClk,
   output logic            fbClk,
   output logic            preClk,
   output logic [2:0]      pumpLevel,
   output logic [4:0]      filterRes,
   output logic [1:0]      filterCap,
   output logic            codeError
);
   import pll_scan_pkg::*;

   logic                 scanClkQ_r;
   logic                 scanRise;
   logic                 pushValid;
   logic                 popValid;
   logic                 popReady;
   logic                 popBit;
   logic                 shift;
   logic [CHAIN_LEN-1:0] chain_r;
   logic [CHAIN_LEN-1:0] cfg_r;
   logic                 loadStb_r;
   logic                 scanDone_r;
   logic [NUM_CNT-1:0]   divClk;
   logic [NUM_CNT-1:0]   pend;
   upd_state_e           state_r;
   logic [2:0]           pumpLevel_r;
   logic [4:0]           filterRes_r;
   logic [1:0]           filterCap_r;
   logic                 codeError_r;
   logic [CP_W-1:0]      cpCode;
   logic [LFR_W-1:0]     lfrCode;
   logic [LFC_W-1:0]     lfcCode;

   // scan clock is sampled as a plain input; one bit buffered per rising edge with scanClkEn high and room free
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         scanClkQ_r <= 1'b0;
      end else begin
         scanClkQ_r <= scanClk;
      end
   end

   assign scanRise  = scanClk & ~scanClkQ_r;
   assign pushValid = scanRise & scanClkEn;
   // chain holds still while the image is being applied
   assign popReady  = (state_r != UPD_APPLY);
   assign shift     = popValid & popReady;

   scan_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .inValid  (pushValid),
      .inReady  (scanReady),
      .inData   (scanData),
      .outValid (popValid),
      .outReady (popReady),
      .outData  (popBit)
   );

   // first bit drifts down to position zero
   // last bit lands at the top
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         chain_r <= '0;
      end else if (shift) begin
         chain_r <= {popBit, chain_r[CHAIN_LEN-1:1]};
      end
   end

   // apply waits for buffered bits to reach the chain
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_r <= UPD_IDLE;
      end else begin
         unique case (state_r)
            UPD_IDLE: begin
               if (scanRise && configUpdate) begin
                  state_r <= UPD_DRAIN;
               end
            end
            UPD_DRAIN: begin
               if (!popValid) begin
                  state_r <= UPD_APPLY;
               end
            end
            UPD_APPLY: begin
               if (!loadStb_r && pend == '0) begin
                  state_r <= UPD_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cfg_r     <= '0;
         loadStb_r <= 1'b0;
      end else begin
         loadStb_r <= (state_r == UPD_DRAIN) && !popValid;
         if ((state_r == UPD_DRAIN) && !popValid) begin
            cfg_r <= chain_r;
         end
      end
   end

   // done high while counters switch over
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         scanDone_r <= 1'b0;
      end else if ((state_r == UPD_DRAIN) && !popValid) begin
         scanDone_r <= 1'b1;
      end else if (state_r == UPD_APPLY && !loadStb_r && pend == '0) begin
         scanDone_r <= 1'b0;
      end
   end

   // separate 8-bit high and low counts
   // bypass at bit 8 of the first group
   for (genvar k = 0; k < NUM_CNT; k++) begin : g_cnt
      pll_div_counter u_cnt (
         .ref_clk   (ref_clk),
         .nrst      (nrst),
         .loadStb   (loadStb_r),
         .highCount (cfg_r[k*CNT_FIELD+HI_OFS +: CNT_BITS]),
         .lowCount  (cfg_r[k*CNT_FIELD+LO_OFS +: CNT_BITS]),
         .bypass    (cfg_r[k*CNT_FIELD+BYP_OFS]),
         .oddSel    (cfg_r[k*CNT_FIELD+ODD_OFS]),
         .divClk    (divClk[k]),
         .pending   (pend[k])
      );
   end

   for (genvar i = 0; i < NUM_POST; i++) begin : g_post
      assign postClk[i] = divClk[IDX_C0-i];
   end

   assign fbClk     = divClk[IDX_M];
   assign preClk    = divClk[IDX_N];
   assign scanDone  = scanDone_r;
   assign pumpLevel = pumpLevel_r;
   assign filterRes = filterRes_r;
   assign filterCap = filterCap_r;
   assign codeError = codeError_r;

   assign cpCode  = cfg_r[CP_BASE +: CP_W];
   assign lfrCode = cfg_r[LF_BASE+LFR_OFS +: LFR_W];
   assign lfcCode = cfg_r[LF_BASE+LFC_OFS +: LFC_W];

   // illegal codes keep the previous setting so the loop never sees
   // an unsupported bandwidth; codeError reports the rejected load
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pumpLevel_r <= CP_SET0;
         filterRes_r <= '0;
         filterCap_r <= LFC_CODE0;
         codeError_r <= 1'b0;
      end else if (loadStb_r) begin
         codeError_r <= 1'b0;
         unique case (cpCode)
            CP_CODE0: pumpLevel_r <= CP_SET0;
            CP_CODE1: pumpLevel_r <= CP_SET1;
            CP_CODE3: pumpLevel_r <= CP_SET3;
            CP_CODE7: pumpLevel_r <= CP_SET7;
            default:  codeError_r <= 1'b1;
         endcase
         if (lfrCode inside {5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13,
                             5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E}) begin
            filterRes_r <= lfrCode;
         end else begin
            codeError_r <= 1'b1;
         end
         if (lfcCode == LFC_CODE0 || lfcCode == LFC_CODE1 ||
             lfcCode == LFC_CODE3) begin
            filterCap_r <= lfcCode;
         end else begin
            codeError_r <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   chain_shift_a: assert property (
      shift |=> chain_r[CHAIN_LEN-1] == $past(popBit))
      else $error("scan bit did not enter the chain top");
   chain_move_a: assert property (
      shift |=> chain_r[CHAIN_LEN-2:0] == $past(chain_r[CHAIN_LEN-1:1]))
      else $error("chain did not move toward position zero");
   chain_hold_a: assert property (
      !shift |=> $stable(chain_r))
      else $error("chain changed without a shift");
   push_seen_a: assert property (
      pushValid && scanReady |=> popValid)
      else $error("gated scan edge lost its bit");
   update_load_a: assert property (
      state_r == UPD_DRAIN && !popValid |=> loadStb_r && cfg_r == $past(chain_r))
      else $error("apply did not load the chain image");
   done_rise_a: assert property (
      loadStb_r |-> scanDone_r ##1 (scanDone_r && pend == '1))
      else $error("done not high while counters pending");
   done_fall_a: assert property (
      $fell(scanDone_r) |-> $past(pend) == '0)
      else $error("done fell before all counters switched");
   pump_decode_a: assert property (
      loadStb_r && cpCode == CP_CODE3 |=> pumpLevel_r == CP_SET3)
      else $error("pump code 110 not decoded to 3");
   res_decode_a: assert property (
      loadStb_r && lfrCode == 5'h1B |=> filterRes_r == 5'h1B)
      else $error("resistor code 27 not taken");
   cap_reject_a: assert property (
      loadStb_r && lfcCode == 2'h2 |=> codeError_r && $stable(filterCap_r))
      else $error("capacitor code 10 not rejected");

   update_done_c: cover property ($fell(scanDone_r));
   full_fifo_c: cover property (!scanReady);
   code_error_c: cover property ($rose(codeError_r));
   drain_wait_c: cover property (state_r == UPD_DRAIN && popValid);

endmodule

`default_nettype wire

// File: pll_scan_pkg.sv
// constants for the pll reconfiguration scan chain: chain layout,
// counter field positions, code tables and buffering depth.
// assumes one system clock that also serves as the vco half-step clock.
`default_nettype none

package pll_scan_pkg;

   // chain geometry
   localparam int CHAIN_LEN  = 144;
   localparam int CNT_FIELD  = 18;
   localparam int NUM_CNT    = 7;
   localparam int NUM_POST   = 5;
   localparam int CNT_BITS   = 8;

   // counter order along the chain, from the first bit shifted in
   localparam int IDX_C4 = 0;
   localparam int IDX_C0 = 4;
   localparam int IDX_M  = 5;
   localparam int IDX_N  = 6;

   // bit positions inside one 18-bit counter field
   localparam int LO_OFS  = 0;
   localparam int BYP_OFS = 8;
   localparam int HI_OFS  = 9;
   localparam int ODD_OFS = 17;

   // charge pump and loop filter groups
   localparam int CP_BASE  = 126;
   localparam int LF_BASE  = 135;
   localparam int CP_W     = 3;
   localparam int LFR_OFS  = 0;
   localparam int LFR_W    = 5;
   localparam int LFC_OFS  = 5;
   localparam int LFC_W    = 2;

   // scan clock limit the controller keeps
   localparam int SCAN_MAX_MHZ = 100;

   // serial bit buffer
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 1;

   // counter step widths: one system clock is half a vco cycle
   localparam int STEP_W = 10;
   localparam logic [STEP_W-1:0] STEP_BYPASS = 10'h002;
   localparam logic [STEP_W-1:0] STEP_ONE    = 10'h001;

   // pump current codes
   localparam logic [2:0] CP_CODE0 = 3'h0;
   localparam logic [2:0] CP_CODE1 = 3'h4;
   localparam logic [2:0] CP_CODE3 = 3'h6;
   localparam logic [2:0] CP_CODE7 = 3'h7;
   localparam logic [2:0] CP_SET0  = 3'h0;
   localparam logic [2:0] CP_SET1  = 3'h1;
   localparam logic [2:0] CP_SET3  = 3'h3;
   localparam logic [2:0] CP_SET7  = 3'h7;

   // capacitor codes
   localparam logic [1:0] LFC_CODE0 = 2'h0;
   localparam logic [1:0] LFC_CODE1 = 2'h1;
   localparam logic [1:0] LFC_CODE3 = 2'h3;

   // update sequencer
   typedef enum logic [1:0] {
      UPD_IDLE,
      UPD_DRAIN,
      UPD_APPLY
   } upd_state_e;

endpackage

`default_nettype wire

// File: scan_ctrl_model.sv
// controller model for the pll reconfiguration scan chain: shifts an
// image in lsb first on a scan clock, then requests the update.
// assumes its tasks are called from one bench process at a time.
`timescale 1ns/1ps
`default_nettype none

module scan_ctrl_model (
   input  wire logic ref_clk,
   output logic      scanClk,
   output logic      scanClkEn,
   output logic      scanData,
   output logic      configUpdate,
   input  wire logic scanReady
);
   initial begin
      scanClk = 1'h0;
      scanClkEn = 1'h0;
      scanData = 1'h0;
      configUpdate = 1'h0;
   end

   // one bit per rise
   // high one step, low at least one: never above 50 MHz
   task automatic put_bit(input logic b, input int slow, output logic ok);
      @(posedge ref_clk);
      scanClk <= 1'h1;
      scanData <= b;
      @(negedge ref_clk);
      ok = scanReady;
      @(posedge ref_clk);
      scanClk <= 1'h0;
      // data no longer qualified: show the inverse, not a held copy
      scanData <= ~b;
      repeat (slow) @(posedge ref_clk);
   endtask

   task automatic send_image(input logic [143:0] img, input int slow);
      logic ok;
      @(posedge ref_clk);
      scanClkEn <= 1'h1;
      @(posedge ref_clk);
      for (int i = 0; i < 144; i++)
         put_bit(img[i], slow, ok);
      @(posedge ref_clk);
      scanClkEn <= 1'h0;
   endtask

   // update on one scan clock cycle
   task automatic apply();
      @(posedge ref_clk);
      configUpdate <= 1'h1;
      scanClk <= 1'h1;
      @(posedge ref_clk);
      configUpdate <= 1'h0;
      scanClk <= 1'h0;
   endtask

   // pushes regardless of ready, so refusals can be counted
   task automatic push_burst(input int n, output int acc);
      logic ok;
      acc = 0;
      @(posedge ref_clk);
      scanClkEn <= 1'h1;
      for (int i = 0; i < n; i++) begin
         put_bit(i[0], 0, ok);
         if (ok === 1'h1)
            acc++;
      end
      @(posedge ref_clk);
      scanClkEn <= 1'h0;
   endtask
endmodule

`default_nettype wire

// File: scan_fifo.sv
// small flip-flop fifo carrying scan bits toward the chain.
// assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module scan_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wrPtr_r;
   logic [PW-1:0]    rdPtr_r;
   logic [PW:0]      count_r;
   logic             push;
   logic             pop;

   assign inReady  = (count_r != (PW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData  = mem_r[rdPtr_r];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_r[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// File: testbench.sv
// self-checking bench for the pll reconfiguration scan chain.
// assumes scan_ctrl_model drives every scan input of the block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import pll_scan_pkg::*;
   logic       ref_clk;
   logic       nrst;
   logic       scanClk, scanClkEn, scanData, configUpdate;
   logic       scanReady, scanDone, fbClk, preClk, codeError;
   logic [4:0] postClk;
   logic [2:0] pumpLevel;
   logic [4:0] filterRes;
   logic [1:0] filterCap;
   int         error_cnt;
   int         checked;

   pll_reconfig_scan_chain pll_reconfig_scan_chain_inst (
      .ref_clk(ref_clk), .nrst(nrst), .scanClk(scanClk),
      .scanClkEn(scanClkEn), .scanData(scanData),
      .configUpdate(configUpdate), .scanReady(scanReady),
      .scanDone(scanDone), .postClk(postClk), .fbClk(fbClk),
      .preClk(preClk), .pumpLevel(pumpLevel), .filterRes(filterRes),
      .filterCap(filterCap), .codeError(codeError));

   scan_ctrl_model scan_ctrl_model_inst (
      .ref_clk(ref_clk), .scanClk(scanClk), .scanClkEn(scanClkEn),
      .scanData(scanData), .configUpdate(configUpdate),
      .scanReady(scanReady));

   always #5 ref_clk = ~ref_clk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'h1) begin
         error_cnt++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask

   task automatic tick(inout int n);
      @(negedge ref_clk);
      n++;
      if (n > 4000) begin
         error_cnt++;
         $display("[ERR] %0t wait bound used up", $time);
         end_sim();
      end
   endtask

   task automatic wait_done(input logic lvl);
      int n;
      n = 0;
      while (scanDone !== lvl)
         tick(n);
   endtask

   // chain field k drives this output
   function automatic logic pick(input int k);
      logic [6:0] w;
      w = {preClk, fbClk, postClk[0], postClk[1], postClk[2], postClk[3],
           postClk[4]};
      return w[k];
   endfunction

   // one full period measured in half-vco steps
   task automatic measure(input int k, input int per, input int hi);
      int n, nh, nl;
      n = 0;
      nh = 0;
      nl = 0;
      while (pick(k) !== 1'h0)
         tick(n);
      while (pick(k) !== 1'h1)
         tick(n);
      while (pick(k) === 1'h1) begin
         nh++;
         tick(n);
      end
      while (pick(k) === 1'h0) begin
         nl++;
         tick(n);
      end
      check(nh == hi && nh + nl == per, $sformatf("clock %0d shape", k));
   endtask

   function automatic logic [17:0] fld(input int hi, input int lo,
                                       input logic byp, input logic odd);
      logic [17:0] f;
      f = '0;
      f[LO_OFS +: 8] = 8'(lo);
      f[HI_OFS +: 8] = 8'(hi);
      f[BYP_OFS] = byp;
      f[ODD_OFS] = odd;
      return f;
   endfunction

   function automatic logic [143:0] img(input logic [2:0] cp,
                                        input logic [4:0] r,
                                        input logic [1:0] c);
      logic [143:0] m;
      m = '0;
      for (int k = 0; k < NUM_CNT; k++)
         m[k*CNT_FIELD +: CNT_FIELD] = fld(0, 0, 1'h1, 1'h0);
      m[CP_BASE +: CP_W] = cp;
      m[LF_BASE+LFR_OFS +: LFR_W] = r;
      m[LF_BASE+LFC_OFS +: LFC_W] = c;
      return m;
   endfunction

   task automatic load(input logic [143:0] m, input int slow);
      scan_ctrl_model_inst.send_image(m, slow);
      scan_ctrl_model_inst.apply();
      wait_done(1'h1);
      wait_done(1'h0);
      @(negedge ref_clk);
   endtask

   task automatic t_reset();
      @(negedge ref_clk);
      check(scanReady === 1'h1 && scanDone === 1'h0, "reset status");
      check(pumpLevel === 3'h0 && filterRes === 5'h00 &&
            filterCap === 2'h0 && codeError === 1'h0, "reset codes");
      measure(4, 2, 1);
      $display("reset test done");
   endtask

   task automatic t_counters();
      logic [143:0] m;
      m = img(CP_CODE3, 5'h1b, LFC_CODE1);
      m[0 +: 18] = fld(2, 1, 1'h0, 1'h0);
      m[18 +: 18] = fld(2, 1, 1'h0, 1'h1);
      m[36 +: 18] = fld(9, 7, 1'h1, 1'h1);
      m[54 +: 18] = fld(4, 6, 1'h0, 1'h0);
      m[72 +: 18] = fld(5, 5, 1'h0, 1'h0);
      m[90 +: 18] = fld(1, 1, 1'h0, 1'h0);
      m[108 +: 18] = fld(3, 2, 1'h0, 1'h0);
      load(m, 2);
      measure(0, 6, 4);
      measure(1, 6, 3);
      measure(2, 2, 1);
      measure(3, 20, 8);
      measure(4, 20, 10);
      measure(5, 4, 2);
      measure(6, 10, 6);
      check(pumpLevel === CP_SET3, "pump setting");
      check(filterRes === 5'h1b, "resistor setting");
      check(filterCap === 2'h1, "capacitor setting");
      $display("counters test done");
   endtask

   task automatic t_codes();
      logic [4:0] rt [11] = '{5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13,
                              5'h14, 5'h18, 5'h1b, 5'h1c, 5'h1e};
      logic [2:0] ct [4] = '{CP_CODE0, CP_CODE1, CP_CODE3, CP_CODE7};
      logic [2:0] st [4] = '{CP_SET0, CP_SET1, CP_SET3, CP_SET7};
      logic [1:0] cc [3] = '{LFC_CODE0, LFC_CODE1, LFC_CODE3};
      for (int i = 0; i < 11; i++) begin
         load(img(ct[i%4], rt[i], cc[i%3]), 0);
         check(pumpLevel === st[i%4], "pump setting");
         check(filterRes === rt[i], "resistor setting");
         check(filterCap === cc[i%3], "capacitor setting");
         check(codeError === 1'h0, "legal codes flagged");
      end
      // illegal patterns must leave the previous setting in place
      load(img(3'h2, 5'h1e, LFC_CODE1), 0);
      check(pumpLevel === CP_SET3 && codeError === 1'h1, "pump kept");
      load(img(CP_CODE3, 5'h01, LFC_CODE1), 0);
      check(filterRes === 5'h1e && codeError === 1'h1, "res kept");
      load(img(CP_CODE3, 5'h1e, 2'h2), 0);
      check(filterCap === 2'h1 && codeError === 1'h1, "cap kept");
      $display("codes test done");
   endtask

   task automatic t_fill();
      logic [143:0] m;
      int acc;
      m = img(CP_CODE0, 5'h00, LFC_CODE0);
      m[0 +: 18] = fld(200, 200, 1'h0, 1'h0);
      load(m, 0);
      // second update waits out the long period, so shifts stall
      scan_ctrl_model_inst.apply();
      wait_done(1'h1);
      scan_ctrl_model_inst.push_burst(FIFO_DEPTH + 1, acc);
      check(acc == FIFO_DEPTH, "full buffer refuses");
      check(scanDone === 1'h1, "update still pending");
      wait_done(1'h0);
      repeat (FIFO_DEPTH + 2) @(negedge ref_clk);
      check(scanReady === 1'h1, "buffer drained");
      measure(0, 800, 400);
      $display("buffer test done");
   endtask

   // controller resets the pll after its last change
   // mid-run reset must drop the long divide back to bypass
   task automatic t_rearm();
      @(posedge ref_clk);
      nrst <= 1'h0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'h1;
      @(negedge ref_clk);
      check(scanDone === 1'h0 && scanReady === 1'h1, "rearm status");
      measure(0, 2, 1);
      $display("rearm test done");
   endtask

   initial begin
      ref_clk = 1'h0;
      nrst = 1'h0;
      error_cnt = 0;
      checked = 0;
      repeat (6) @(posedge ref_clk);
      nrst <= 1'h1;
      t_reset();
      t_counters();
      t_codes();
      t_fill();
      t_rearm();
      end_sim();
   end
endmodule

`default_nettype wire
